//--- shared/dbs_pkg.sv
package dbs_pkg;

    // -------------------------------------------------------------
    // cycle ownership
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_DMA,
        CYC_MASTER
    } dbs_cycle_e;

    // -------------------------------------------------------------
    // command inputs seen by the steering decode
    // -------------------------------------------------------------
    typedef struct packed {
        logic dma_mem_read_n;
        logic mem_read_cmd_n;
        logic mem_write_cmd_n;
        logic io_read_cmd_n;
        logic io_write_cmd_n;
        logic sys_addr_bit0;
        logic sys_high_byte_enable_n;
        logic wide_target_sel_n;
        logic rom_select_n;
        logic offboard_target;
    } dbs_cmd_s;

    // -------------------------------------------------------------
    // transceiver steering outputs
    // -------------------------------------------------------------
    typedef struct packed {
        logic xfer_direction;
        logic low_lane_enable_n;
        logic high_lane_enable_n;
        logic swap_enable_n;
        logic swap_direction;
        logic swap_cycle_flag;
    } dbs_steer_s;

    // -------------------------------------------------------------
    // encodings and reset value
    // -------------------------------------------------------------
    localparam logic XFER_DIR_READ = 1'h1;
    localparam logic XFER_DIR_WRITE = 1'h0;
    localparam logic SWAP_DIR_READ = 1'h1;
    localparam logic SWAP_DIR_WRITE = 1'h0;
    localparam logic EN_ON = 1'h0;
    localparam logic EN_OFF = 1'h1;
    localparam logic SWAP_FLAG_ON = 1'h1;
    localparam logic SWAP_FLAG_OFF = 1'h0;

    localparam dbs_steer_s STEER_RST = '{
        xfer_direction: XFER_DIR_WRITE,
        low_lane_enable_n: EN_OFF,
        high_lane_enable_n: EN_OFF,
        swap_enable_n: EN_OFF,
        swap_direction: SWAP_DIR_WRITE,
        swap_cycle_flag: SWAP_FLAG_OFF
    };

endpackage

//--- shared/dbs_link_if.sv
interface dbs_link_if;
    logic hold_ack;
    logic hold_ack_copy;
    logic ext_master_n;
    dbs_pkg::dbs_cycle_e cycle;

    modport top (
        output hold_ack,
        output hold_ack_copy,
        output ext_master_n,
        input cycle
    );

    modport owner (
        input hold_ack,
        input hold_ack_copy,
        input ext_master_n,
        output cycle
    );
endinterface

//--- core/dbs_owner.sv
module dbs_owner (
    // bus ownership
    dbs_link_if.owner link
);

    // -------------------------------------------------------------
    // who owns the bus this cycle
    // -------------------------------------------------------------
    // processor cycles fall to idle: they are steered elsewhere
    always_comb
    begin
        if (link.hold_ack && !link.ext_master_n)
        begin
            link.cycle = dbs_pkg::CYC_MASTER;
        end
        else if (link.hold_ack && link.hold_ack_copy && link.ext_master_n)
        begin
            link.cycle = dbs_pkg::CYC_DMA;
        end
        else
        begin
            link.cycle = dbs_pkg::CYC_IDLE;
        end
    end

endmodule

//--- core/dbs_steer.sv
// What this block does
// - 16-bit DMA I/O into memory: direction 0, both lanes on, swap off.
// - 8-bit DMA odd system memory to I/O: lanes off, swap on, swap direction 0.
// - 8-bit DMA I/O to odd system memory: lanes off, swap on, swap direction 1.
// - any other DMA cycle keeps swap off; wide memory to I/O and on-board byte moves open lanes, the rest all off.
// - master cycle only when hold acknowledge high and master line low.
// - in master cycles memory strobes with offboard_target low pick on-board memory.
// - master low-byte memory read with wide_target_sel_n high: direction 1, low lane on only.
// - master low-byte memory write: direction 0, low lane on only.
// - master high-byte memory read with wide_target_sel_n high: direction 1, high lane on only.
// - master high-byte memory write: direction 0, high lane on only.
// - master 16-bit memory read with wide_target_sel_n high: direction 1, both lanes on; with it low, direction 0 and all lanes off.
// - master 16-bit memory write: direction 0, both lanes on.
// - master high-byte read from 8-bit target: swap on, swap direction 1.
// - master high-byte write to 8-bit target: swap on, swap direction 0.
module dbs_steer (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // bus ownership
    input wire logic hold_ack,
    input wire logic hold_ack_copy,
    input wire logic ext_master_n,
    // command strobes
    input wire logic dma_mem_read_n,
    input wire logic mem_read_cmd_n,
    input wire logic mem_write_cmd_n,
    input wire logic io_read_cmd_n,
    input wire logic io_write_cmd_n,
    // address and target selects
    input wire logic sys_addr_bit0,
    input wire logic sys_high_byte_enable_n,
    input wire logic wide_target_sel_n,
    input wire logic rom_select_n,
    input wire logic offboard_target,
    // transceiver steering
    output logic xfer_direction,
    output logic low_lane_enable_n,
    output logic high_lane_enable_n,
    output logic swap_enable_n,
    output logic swap_direction,
    output logic swap_cycle_flag
);

    // -------------------------------------------------------------
    // ownership classification
    // -------------------------------------------------------------
    dbs_link_if link ();

    assign link.hold_ack = hold_ack;
    assign link.hold_ack_copy = hold_ack_copy;
    assign link.ext_master_n = ext_master_n;

    dbs_owner u_owner (
        .link(link.owner)
    );

    dbs_pkg::dbs_cmd_s cmd;

    assign cmd = '{
        dma_mem_read_n: dma_mem_read_n,
        mem_read_cmd_n: mem_read_cmd_n,
        mem_write_cmd_n: mem_write_cmd_n,
        io_read_cmd_n: io_read_cmd_n,
        io_write_cmd_n: io_write_cmd_n,
        sys_addr_bit0: sys_addr_bit0,
        sys_high_byte_enable_n: sys_high_byte_enable_n,
        wide_target_sel_n: wide_target_sel_n,
        rom_select_n: rom_select_n,
        offboard_target: offboard_target
    };

    // -------------------------------------------------------------
    // DMA steering
    // -------------------------------------------------------------
    function automatic dbs_pkg::dbs_steer_s dma_steer(input dbs_pkg::dbs_cmd_s c);
        dbs_pkg::dbs_steer_s s;
        logic to_mem;
        logic from_mem;
        logic odd_hi;
        s = dbs_pkg::STEER_RST;
        to_mem = !c.io_read_cmd_n && !c.mem_write_cmd_n
                 && c.dma_mem_read_n && c.io_write_cmd_n;
        from_mem = !c.dma_mem_read_n && !c.io_write_cmd_n
                   && c.mem_write_cmd_n && c.io_read_cmd_n;
        odd_hi = c.sys_addr_bit0 && !c.sys_high_byte_enable_n;
        if (to_mem || from_mem)
        begin
            if (!c.sys_addr_bit0 && !c.sys_high_byte_enable_n)
            begin
                s.xfer_direction = from_mem ? dbs_pkg::XFER_DIR_READ
                                            : dbs_pkg::XFER_DIR_WRITE;
                s.low_lane_enable_n = dbs_pkg::EN_ON;
                s.high_lane_enable_n = dbs_pkg::EN_ON;
            end
            else if (odd_hi && !c.rom_select_n)
            begin
                // byte moves across lanes, so both straight lanes stay off
                s.swap_enable_n = dbs_pkg::EN_ON;
                s.swap_cycle_flag = dbs_pkg::SWAP_FLAG_ON;
                s.swap_direction = to_mem ? dbs_pkg::SWAP_DIR_READ
                                          : dbs_pkg::SWAP_DIR_WRITE;
            end
            else if (!c.offboard_target && !c.sys_addr_bit0 && c.sys_high_byte_enable_n)
            begin
                s.xfer_direction = from_mem ? dbs_pkg::XFER_DIR_READ
                                            : dbs_pkg::XFER_DIR_WRITE;
                s.low_lane_enable_n = dbs_pkg::EN_ON;
            end
            else if (!c.offboard_target && odd_hi)
            begin
                s.xfer_direction = from_mem ? dbs_pkg::XFER_DIR_READ
                                            : dbs_pkg::XFER_DIR_WRITE;
                s.high_lane_enable_n = dbs_pkg::EN_ON;
            end
        end
        return s;
    endfunction

    // -------------------------------------------------------------
    // external master steering
    // -------------------------------------------------------------
    // no 8-bit master case exists: a master is taken as 16-bit wide
    function automatic dbs_pkg::dbs_steer_s master_steer(input dbs_pkg::dbs_cmd_s c);
        dbs_pkg::dbs_steer_s s;
        logic any_rd;
        logic any_wr;
        logic mem_any;
        logic io_any;
        logic odd_hi;
        s = dbs_pkg::STEER_RST;
        any_rd = !c.mem_read_cmd_n || !c.io_read_cmd_n;
        any_wr = !c.mem_write_cmd_n || !c.io_write_cmd_n;
        mem_any = !c.mem_read_cmd_n || !c.mem_write_cmd_n;
        io_any = !c.io_read_cmd_n || !c.io_write_cmd_n;
        odd_hi = c.sys_addr_bit0 && !c.sys_high_byte_enable_n;
        // conflicting strobes would fight on the lanes: leave all off
        if ((any_rd != any_wr) && !(mem_any && io_any))
        begin
            s.xfer_direction = any_rd ? dbs_pkg::XFER_DIR_READ
                                      : dbs_pkg::XFER_DIR_WRITE;
            if (mem_any && !c.offboard_target)
            begin
                if (any_rd && !c.wide_target_sel_n)
                begin
                    s.xfer_direction = dbs_pkg::XFER_DIR_WRITE;
                end
                else if (!c.sys_addr_bit0 && c.sys_high_byte_enable_n)
                begin
                    s.low_lane_enable_n = dbs_pkg::EN_ON;
                end
                else if (odd_hi)
                begin
                    s.high_lane_enable_n = dbs_pkg::EN_ON;
                end
                else if (!c.sys_addr_bit0 && !c.sys_high_byte_enable_n)
                begin
                    s.low_lane_enable_n = dbs_pkg::EN_ON;
                    s.high_lane_enable_n = dbs_pkg::EN_ON;
                end
            end
            else if (odd_hi)
            begin
                s.swap_enable_n = dbs_pkg::EN_ON;
                s.swap_cycle_flag = dbs_pkg::SWAP_FLAG_ON;
                s.swap_direction = any_rd ? dbs_pkg::SWAP_DIR_READ
                                          : dbs_pkg::SWAP_DIR_WRITE;
            end
        end
        return s;
    endfunction

    // -------------------------------------------------------------
    // steering register
    // -------------------------------------------------------------
    dbs_pkg::dbs_steer_s steer;
    dbs_pkg::dbs_steer_s next_steer;

    always_comb
    begin
        case (link.cycle)
            dbs_pkg::CYC_DMA: next_steer = dma_steer(cmd);
            dbs_pkg::CYC_MASTER: next_steer = master_steer(cmd);
            default: next_steer = dbs_pkg::STEER_RST;
        endcase
    end

    // registered so the enables never glitch while strobes settle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            steer <= dbs_pkg::STEER_RST;
        end
        else
        begin
            steer <= next_steer;
        end
    end

    assign xfer_direction = steer.xfer_direction;
    assign low_lane_enable_n = steer.low_lane_enable_n;
    assign high_lane_enable_n = steer.high_lane_enable_n;
    assign swap_enable_n = steer.swap_enable_n;
    assign swap_direction = steer.swap_direction;
    assign swap_cycle_flag = steer.swap_cycle_flag;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic dma_own;
    logic mst_own;

    assign dma_own = hold_ack && hold_ack_copy && ext_master_n;
    assign mst_own = hold_ack && !ext_master_n;

    a_dma_wide_in: assert property (
        (dma_own && dma_mem_read_n && !mem_write_cmd_n && !io_read_cmd_n && io_write_cmd_n
         && !sys_addr_bit0 && !sys_high_byte_enable_n)
        |=> (!xfer_direction && !low_lane_enable_n && !high_lane_enable_n && swap_enable_n))
        else $error("wide DMA into memory steered wrongly");

    a_dma_swap_out: assert property (
        (dma_own && !dma_mem_read_n && mem_write_cmd_n && io_read_cmd_n && !io_write_cmd_n
         && sys_addr_bit0 && !sys_high_byte_enable_n && !rom_select_n)
        |=> (low_lane_enable_n && high_lane_enable_n && !swap_enable_n && !swap_direction))
        else $error("odd DMA to I/O not swapped toward I/O");

    a_dma_swap_in: assert property (
        (dma_own && dma_mem_read_n && !mem_write_cmd_n && !io_read_cmd_n && io_write_cmd_n
         && sys_addr_bit0 && !sys_high_byte_enable_n && !rom_select_n)
        |=> (low_lane_enable_n && high_lane_enable_n && !swap_enable_n && swap_direction))
        else $error("odd DMA from I/O not swapped toward memory");

    a_dma_other_off: assert property (
        (dma_own && !dma_mem_read_n && !mem_write_cmd_n)
        |=> (low_lane_enable_n && high_lane_enable_n && swap_enable_n))
        else $error("conflicting DMA strobes enabled a buffer");

    a_idle_off: assert property (
        (!hold_ack) |=> (low_lane_enable_n && high_lane_enable_n && swap_enable_n))
        else $error("buffers enabled without hold acknowledge");

    a_mst_low_rd: assert property (
        (mst_own && !mem_read_cmd_n && mem_write_cmd_n && io_read_cmd_n && io_write_cmd_n
         && !offboard_target && !sys_addr_bit0 && sys_high_byte_enable_n && wide_target_sel_n)
        |=> (xfer_direction && !low_lane_enable_n && high_lane_enable_n && swap_enable_n))
        else $error("master low byte read steered wrongly");

    a_mst_high_wr: assert property (
        (mst_own && mem_read_cmd_n && !mem_write_cmd_n && io_read_cmd_n && io_write_cmd_n
         && !offboard_target && sys_addr_bit0 && !sys_high_byte_enable_n)
        |=> (!xfer_direction && low_lane_enable_n && !high_lane_enable_n && swap_enable_n))
        else $error("master high byte write steered wrongly");

    a_mst_wide_rd: assert property (
        (mst_own && !mem_read_cmd_n && mem_write_cmd_n && io_read_cmd_n && io_write_cmd_n
         && !offboard_target && !sys_addr_bit0 && !sys_high_byte_enable_n && wide_target_sel_n)
        |=> (xfer_direction && !low_lane_enable_n && !high_lane_enable_n))
        else $error("master wide read did not open both lanes");

    a_mst_swap_io: assert property (
        (mst_own && !io_read_cmd_n && io_write_cmd_n && mem_read_cmd_n && mem_write_cmd_n
         && sys_addr_bit0 && !sys_high_byte_enable_n)
        |=> (low_lane_enable_n && high_lane_enable_n && !swap_enable_n && swap_direction))
        else $error("master odd I/O read not swapped");

    a_mst_low_wr: assert property (
        (mst_own && mem_read_cmd_n && !mem_write_cmd_n && io_read_cmd_n && io_write_cmd_n
         && !offboard_target && !sys_addr_bit0 && sys_high_byte_enable_n)
        |=> (!xfer_direction && !low_lane_enable_n && high_lane_enable_n && swap_enable_n))
        else $error("master low byte write steered wrongly");

    a_mst_high_rd: assert property (
        (mst_own && !mem_read_cmd_n && mem_write_cmd_n && io_read_cmd_n && io_write_cmd_n
         && !offboard_target && sys_addr_bit0 && !sys_high_byte_enable_n && wide_target_sel_n)
        |=> (xfer_direction && low_lane_enable_n && !high_lane_enable_n && swap_enable_n))
        else $error("master high byte read steered wrongly");

    a_mst_wide_wr: assert property (
        (mst_own && mem_read_cmd_n && !mem_write_cmd_n && io_read_cmd_n && io_write_cmd_n
         && !offboard_target && !sys_addr_bit0 && !sys_high_byte_enable_n)
        |=> (!xfer_direction && !low_lane_enable_n && !high_lane_enable_n && swap_enable_n))
        else $error("master wide write did not open both lanes");

    a_mst_swap_wr: assert property (
        (mst_own && io_read_cmd_n && !io_write_cmd_n && mem_read_cmd_n && mem_write_cmd_n
         && sys_addr_bit0 && !sys_high_byte_enable_n)
        |=> (low_lane_enable_n && high_lane_enable_n && !swap_enable_n && !swap_direction))
        else $error("master odd I/O write not swapped");

    a_mst_sys_rd: assert property (
        (mst_own && !mem_read_cmd_n && mem_write_cmd_n && io_read_cmd_n && io_write_cmd_n
         && offboard_target && sys_addr_bit0 && !sys_high_byte_enable_n)
        |=> (low_lane_enable_n && high_lane_enable_n && !swap_enable_n && swap_direction))
        else $error("master odd system memory read not swapped");

    a_mst_mixed_off: assert property (
        (mst_own && !mem_read_cmd_n && !mem_write_cmd_n)
        |=> (low_lane_enable_n && high_lane_enable_n && swap_enable_n))
        else $error("master read and write together enabled a buffer");

    a_swap_exclusive: assert property (
        (!swap_enable_n) |-> (low_lane_enable_n && high_lane_enable_n && swap_cycle_flag))
        else $error("swap path open together with a straight lane");

    c_dma_wide: cover property (
        !low_lane_enable_n && !high_lane_enable_n && !xfer_direction && $past(dma_own));
    c_dma_swap: cover property (!swap_enable_n && $past(dma_own));
    c_mst_low: cover property (!low_lane_enable_n && high_lane_enable_n && $past(mst_own));
    c_mst_swap: cover property (!swap_enable_n && swap_direction && $past(mst_own));

endmodule

//--- tb/dbs_bus_partner.sv
module dbs_bus_partner (
    // clock
    input wire logic core_clk,
    // request from the bench: 0 processor, 1 dma, 2 master, 3 master line without hold
    input wire logic [1:0] own,
    input wire logic [9:0] cmd,
    // bus ownership
    output logic hold_ack = 1'h0,
    output logic hold_ack_copy = 1'h0,
    output logic ext_master_n = 1'h1,
    // strobes, address and selects
    output logic dma_mem_read_n = 1'h1,
    output logic mem_read_cmd_n = 1'h1,
    output logic mem_write_cmd_n = 1'h1,
    output logic io_read_cmd_n = 1'h1,
    output logic io_write_cmd_n = 1'h1,
    output logic sys_addr_bit0 = 1'h0,
    output logic sys_high_byte_enable_n = 1'h1,
    output logic wide_target_sel_n = 1'h1,
    output logic rom_select_n = 1'h1,
    output logic offboard_target = 1'h0
);
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------------------
    // bus drive, changed on the falling edge only
    // -------------------------------------------------------------
    always @(negedge core_clk)
    begin
        hold_ack <= (own == 2'h1) || (own == 2'h2);
        hold_ack_copy <= (own == 2'h1);
        ext_master_n <= !own[1];
        if (own == 2'h0)
        begin
            // strobes have pull-ups; undriven lines wander so stale values never help
            {dma_mem_read_n, mem_read_cmd_n, mem_write_cmd_n} <= 3'h7;
            {io_read_cmd_n, io_write_cmd_n, wide_target_sel_n, rom_select_n} <= 4'hF;
            sys_addr_bit0 <= !sys_addr_bit0;
            sys_high_byte_enable_n <= !sys_high_byte_enable_n;
            offboard_target <= !offboard_target;
        end
        else
        begin
            // dma and master requests put the bench cmd word on the bus as given
            {dma_mem_read_n, mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n,
                io_write_cmd_n, sys_addr_bit0, sys_high_byte_enable_n,
                wide_target_sel_n, rom_select_n, offboard_target} <= cmd;
        end
    end
endmodule

//--- tb/dbs_steer_tb.sv
module dbs_steer_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk;
    logic rst;
    logic [1:0] own;
    logic [9:0] cmd;
    logic hold_ack, hold_ack_copy, ext_master_n, dma_mem_read_n, mem_read_cmd_n;
    logic mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n, sys_addr_bit0;
    logic sys_high_byte_enable_n, wide_target_sel_n, rom_select_n, offboard_target;
    logic xfer_direction, low_lane_enable_n, high_lane_enable_n;
    logic swap_enable_n, swap_direction, swap_cycle_flag;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    dbs_bus_partner u_partner (.core_clk(core_clk), .own(own), .cmd(cmd),
        .hold_ack(hold_ack), .hold_ack_copy(hold_ack_copy), .ext_master_n(ext_master_n),
        .dma_mem_read_n(dma_mem_read_n), .mem_read_cmd_n(mem_read_cmd_n),
        .mem_write_cmd_n(mem_write_cmd_n), .io_read_cmd_n(io_read_cmd_n),
        .io_write_cmd_n(io_write_cmd_n), .sys_addr_bit0(sys_addr_bit0),
        .sys_high_byte_enable_n(sys_high_byte_enable_n),
        .wide_target_sel_n(wide_target_sel_n), .rom_select_n(rom_select_n),
        .offboard_target(offboard_target));

    dbs_steer u_dut (.core_clk(core_clk), .rst(rst), .hold_ack(hold_ack),
        .hold_ack_copy(hold_ack_copy), .ext_master_n(ext_master_n),
        .dma_mem_read_n(dma_mem_read_n), .mem_read_cmd_n(mem_read_cmd_n),
        .mem_write_cmd_n(mem_write_cmd_n), .io_read_cmd_n(io_read_cmd_n),
        .io_write_cmd_n(io_write_cmd_n), .sys_addr_bit0(sys_addr_bit0),
        .sys_high_byte_enable_n(sys_high_byte_enable_n),
        .wide_target_sel_n(wide_target_sel_n), .rom_select_n(rom_select_n),
        .offboard_target(offboard_target), .xfer_direction(xfer_direction),
        .low_lane_enable_n(low_lane_enable_n), .high_lane_enable_n(high_lane_enable_n),
        .swap_enable_n(swap_enable_n), .swap_direction(swap_direction),
        .swap_cycle_flag(swap_cycle_flag));

    // -------------------------------------------------------------
    // clock, timeout and closing
    // -------------------------------------------------------------
    initial
    begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    // the whole run needs about 60 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks made %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // -------------------------------------------------------------
    // one bus cycle: request, one cycle of latency, then compare
    // cmd: dmamr memr memw ior iow a0 bhe_n wide_n rom_n offboard
    // exp: xdir lo_n hi_n swap_n swap_dir flag; swap_dir masked where it is free
    // -------------------------------------------------------------
    task automatic step(input logic [1:0] o, input logic [9:0] c, input logic [5:0] e,
        input logic sd_care, input string what);
        logic [5:0] seen;
        logic [5:0] m;
        m = sd_care ? 6'h3F : 6'h3D;
        @(posedge core_clk);
        own <= o;
        cmd <= c;
        @(negedge core_clk);
        @(negedge core_clk);
        seen = {xfer_direction, low_lane_enable_n, high_lane_enable_n,
            swap_enable_n, swap_direction, swap_cycle_flag};
        checked++;
        if ((seen & m) !== (e & m))
        begin
            num_errors++;
            $display("FAIL %s expected %b seen %b", what, e & m, seen & m);
        end
    endtask

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_dma_wide();
        step(2'h1, 10'h326, 6'h04, 1'h0, "dma wide io to memory");
        step(2'h1, 10'h327, 6'h04, 1'h0, "dma wide io to memory offboard");
        $display("test dma_wide done");
    endtask

    task automatic t_dma_swap();
        step(2'h1, 10'h1D5, 6'h19, 1'h1, "dma odd memory to io");
        step(2'h1, 10'h335, 6'h1B, 1'h1, "dma io to odd memory");
        $display("test dma_swap done");
    endtask

    task automatic t_dma_other();
        step(2'h1, 10'h156, 6'h1C, 1'h1, "dma conflicting strobes");
        step(2'h1, 10'h337, 6'h1C, 1'h1, "dma odd system memory no rom");
        step(2'h1, 10'h1CE, 6'h2C, 1'h1, "dma even on-board memory to io");
        step(2'h1, 10'h336, 6'h14, 1'h1, "dma io to odd on-board memory");
        step(2'h1, 10'h3D6, 6'h1C, 1'h1, "dma with master-only strobes");
        $display("test dma_other done");
    endtask

    task automatic t_master_onboard();
        step(2'h2, 10'h2EE, 6'h2C, 1'h0, "master low byte read");
        step(2'h2, 10'h36E, 6'h0C, 1'h0, "master low byte write");
        step(2'h2, 10'h2F6, 6'h34, 1'h0, "master high byte read");
        step(2'h2, 10'h376, 6'h14, 1'h0, "master high byte write");
        step(2'h2, 10'h2E6, 6'h24, 1'h0, "master wide read");
        step(2'h2, 10'h366, 6'h04, 1'h0, "master wide write");
        step(2'h2, 10'h3A6, 6'h3C, 1'h1, "master even io read");
        step(2'h2, 10'h2EA, 6'h1C, 1'h1, "master read with wide select");
        $display("test master_onboard done");
    endtask

    task automatic t_master_swap();
        step(2'h2, 10'h3B6, 6'h3B, 1'h1, "master odd io read");
        step(2'h2, 10'h2F7, 6'h3B, 1'h1, "master odd system memory read");
        step(2'h2, 10'h3D6, 6'h19, 1'h1, "master odd io write");
        step(2'h2, 10'h377, 6'h19, 1'h1, "master odd system memory write");
        $display("test master_swap done");
    endtask

    task automatic t_ownership();
        step(2'h3, 10'h2E6, 6'h1C, 1'h1, "master line without hold");
        step(2'h2, 10'h266, 6'h1C, 1'h1, "master read and write together");
        step(2'h0, 10'h2E6, 6'h1C, 1'h1, "processor owns the bus");
        step(2'h2, 10'h2E6, 6'h24, 1'h0, "master back after idle");
        $display("test ownership done");
    endtask

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        rst = 1'h1;
        own = 2'h0;
        cmd = 10'h3FF;
        repeat (4) @(negedge core_clk);
        checked++;
        if ({xfer_direction, low_lane_enable_n, high_lane_enable_n, swap_enable_n,
            swap_direction, swap_cycle_flag} !== dbs_pkg::STEER_RST)
        begin
            num_errors++;
            $display("FAIL outputs in reset expected %b seen %b", dbs_pkg::STEER_RST,
                {xfer_direction, low_lane_enable_n, high_lane_enable_n, swap_enable_n,
                swap_direction, swap_cycle_flag});
        end
        rst = 1'h0;
        $display("test reset done");
        t_dma_wide();
        t_dma_swap();
        t_dma_other();
        t_master_onboard();
        t_master_swap();
        t_ownership();
        close_out();
    end
endmodule
